// *** eeprom_seg_pkg.sv ***
// Shared constants, states and default command list for the segment interpreter
package eeprom_seg_pkg;

  // Host-side address map
  localparam int HOST_AW = 12;
  localparam logic [11:0] LIST_BASE = 12'ha00;
  localparam logic [11:0] LIST_LAST = 12'haff;
  localparam logic [11:0] COMMIT_OFS = 12'h232;
  localparam logic [11:0] PENDING_OFS = 12'hb00;
  localparam logic [11:0] SAVE_OFS = 12'hb03;
  localparam int TRIG_BIT = 0;

  // Command byte layout
  localparam int KIND_BIT = 7;
  localparam logic [6:0] OP_COMMIT_CODE = 7'h00;
  localparam logic [6:0] OP_END_CODE = 7'h7f;

  // Widths and reset values
  localparam int REG_AW = 16;
  localparam int NV_AW_DEF = 10;
  localparam int FIFO_DEPTH_DEF = 4;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] LIST_FILL = 8'hff;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_CMD    = 7'b0000010,
    ST_HI     = 7'b0000100,
    ST_LO     = 7'b0001000,
    ST_MOVE   = 7'b0010000,
    ST_DRAIN  = 7'b0100000,
    ST_FINISH = 7'b1000000
  } walk_state_t;

  // Power-up list: whole register space in five ranges, then commit, then end
  function automatic logic [7:0] list_default(input logic [7:0] idx, input logic [6:0] commit_code,
                                              input logic [6:0] end_code);
    logic [7:0] v;
    v = LIST_FILL;
    case (idx)
      8'h00, 8'h03, 8'h06, 8'h09: v = 8'h7f;
      8'h01, 8'h02, 8'h04, 8'h08, 8'h0e: v = 8'h00;
      8'h05, 8'h0b: v = 8'h80;
      8'h07, 8'h0a: v = 8'h01;
      8'h0c: v = 8'h33;
      8'h0d: v = 8'h02;
      8'h0f: v = {1'b1, commit_code};
      8'h10: v = {1'b1, end_code};
      default: v = {1'b1, end_code};
    endcase
    return v;
  endfunction

endpackage

// *** eeprom_segment_interpreter.sv ***
// Command-list interpreter moving register ranges to and from nonvolatile memory
//
// How it works
// - 256-byte list at 0xa00..0xaff holds data-transfer entries and operational codes.
// - Top bit clear means data transfer; low seven bits are length minus one.
// - Byte count is the length field plus one.
// - Next two list bytes give start register address, high byte first.
// - Top bit set means the byte is an operational code.
// - Commit code pulses the same copy as writing one to 0x232.
// - End code stops the walk and finishes the save or load.
// - Only the named ranges move, in both directions.
// - Reset list covers all registers, then commits, then ends.
// - Writing one to 0x232 gives a commit pulse on the next edge.
// - Pending flag at 0xb00 reads one until the move completes.
// - Save trigger at 0xb03 starts a save and clears when it ends.
`timescale 1ns/10ps
`default_nettype none

module seg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Honest full and empty straight from the occupancy count
  assign in_ready = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_ptr_r];

  // Storage has no reset; only the pointers and the count need a defined value
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // seg_fifo

module eeprom_segment_interpreter #(
  parameter logic [6:0] COMMIT_CODE = eeprom_seg_pkg::OP_COMMIT_CODE,
  parameter logic [6:0] END_CODE = eeprom_seg_pkg::OP_END_CODE,
  parameter int NV_AW = eeprom_seg_pkg::NV_AW_DEF,
  parameter int FIFO_DEPTH = eeprom_seg_pkg::FIFO_DEPTH_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [eeprom_seg_pkg::HOST_AW-1:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  input wire logic load_req,
  output logic commit_pulse,
  output logic pending,
  output logic [eeprom_seg_pkg::REG_AW-1:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  output logic [NV_AW-1:0] nv_rd_addr,
  input wire logic [7:0] nv_rd_data,
  output logic nv_wr_valid,
  input wire logic nv_wr_ready,
  output logic [NV_AW-1:0] nv_wr_addr,
  output logic [7:0] nv_wr_data,
  output logic reg_wr_valid,
  input wire logic reg_wr_ready,
  output logic [eeprom_seg_pkg::REG_AW-1:0] reg_wr_addr,
  output logic [7:0] reg_wr_data
);
  import eeprom_seg_pkg::*;

  localparam int FW = NV_AW + REG_AW + 8;

  walk_state_t state_r, state_nxt;
  logic [7:0] list_mem [0:255];
  logic [7:0] ptr_r;
  logic [REG_AW-1:0] cur_addr_r;
  logic [7:0] count_r;
  logic [NV_AW-1:0] nv_idx_r;
  logic save_dir_r, save_trig_r, pending_r, end_seen_r, commit_r;
  logic [7:0] host_rdata_r;
  logic load_s1_r, load_s2_r, load_s3_r;
  logic f_in_ready, f_out_valid, f_out_ready;
  logic [FW-1:0] f_out_data;

  // Host decode
  wire in_list = (host_addr[11:8] == LIST_BASE[11:8]);
  wire wr_list = host_wr & in_list;
  wire wr_commit = host_wr & (host_addr == COMMIT_OFS) & host_wdata[TRIG_BIT];
  wire wr_save = host_wr & (host_addr == SAVE_OFS) & host_wdata[TRIG_BIT];
  wire idle = (state_r == ST_IDLE);
  wire load_rise = load_s2_r & ~load_s3_r;
  wire start_save = wr_save & idle;
  wire start_load = load_rise & idle & ~wr_save;
  wire start = start_save | start_load;

  // Command byte decode
  wire [7:0] cmd_byte = list_mem[ptr_r];
  wire is_op = cmd_byte[KIND_BIT];
  wire is_end = is_op & (cmd_byte[6:0] == END_CODE);
  wire is_commit = is_op & (cmd_byte[6:0] == COMMIT_CODE);
  wire [7:0] len_count = {1'b0, cmd_byte[6:0]} + 8'h01;
  wire push = (state_r == ST_MOVE) & f_in_ready;
  wire drained = (state_r == ST_DRAIN) & ~f_out_valid;
  wire [7:0] src_data = save_dir_r ? reg_rd_data : nv_rd_data;

  // Walk sequencing; an unknown opcode is stepped over as a single byte
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (start) state_nxt = ST_CMD;
      ST_CMD: begin
        if (is_end || is_commit) state_nxt = ST_DRAIN;
        else if (is_op) state_nxt = ST_CMD;
        else state_nxt = ST_HI;
      end
      ST_HI: state_nxt = ST_LO;
      ST_LO: state_nxt = ST_MOVE;
      ST_MOVE: if (push && count_r == 8'h01) state_nxt = ST_CMD;
      ST_DRAIN: if (drained) state_nxt = end_seen_r ? ST_FINISH : ST_CMD;
      ST_FINISH: state_nxt = ST_IDLE;
    endcase
  end

  // Read mux; reserved bits and unmapped offsets read zero
  wire [7:0] rd_mux = in_list ? list_mem[host_addr[7:0]] :
                      (host_addr == PENDING_OFS) ? {7'h00, pending_r} :
                      (host_addr == SAVE_OFS) ? {7'h00, save_trig_r} : 8'h00;

  assign host_rdata = host_rdata_r;
  assign commit_pulse = commit_r;
  assign pending = pending_r;
  assign reg_rd_addr = cur_addr_r;
  assign nv_rd_addr = nv_idx_r;
  assign nv_wr_valid = f_out_valid & save_dir_r;
  assign reg_wr_valid = f_out_valid & ~save_dir_r;
  assign f_out_ready = save_dir_r ? nv_wr_ready : reg_wr_ready;
  assign nv_wr_addr = f_out_data[FW-1 -: NV_AW];
  assign reg_wr_addr = f_out_data[8 +: REG_AW];
  assign reg_wr_data = f_out_data[7:0];
  assign nv_wr_data = f_out_data[7:0];

  // List storage with its power-up contents; a constant per byte under reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) list_mem[i] <= list_default(8'(i), COMMIT_CODE, END_CODE);
    end else if (wr_list) begin
      list_mem[host_addr[7:0]] <= host_wdata;
    end
  end

  // Load request arrives from outside: two stages, then an edge detector
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      load_s1_r <= 1'b0;
      load_s2_r <= 1'b0;
      load_s3_r <= 1'b0;
    end else begin
      load_s1_r <= load_req;
      load_s2_r <= load_s1_r;
      load_s3_r <= load_s2_r;
    end
  end

  // List pointer and entry fields
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptr_r <= PTR_RESET;
      cur_addr_r <= '0;
      count_r <= 8'h00;
    end else begin
      if (start) ptr_r <= PTR_RESET;
      else if ((state_r == ST_CMD && !is_end) || state_r == ST_HI || state_r == ST_LO) ptr_r <= ptr_r + 8'h01;
      if (state_r == ST_CMD) count_r <= len_count;
      if (state_r == ST_HI) cur_addr_r[15:8] <= cmd_byte;
      if (state_r == ST_LO) cur_addr_r[7:0] <= cmd_byte;
      if (push) begin
        cur_addr_r <= cur_addr_r + 16'h0001;
        count_r <= count_r - 8'h01;
      end
    end
  end

  // Transfer bookkeeping; starts come only from idle so set and clear never meet
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      nv_idx_r <= '0;
      save_dir_r <= 1'b0;
      save_trig_r <= 1'b0;
      pending_r <= 1'b0;
      end_seen_r <= 1'b0;
      commit_r <= 1'b0;
      host_rdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        nv_idx_r <= '0;
        save_dir_r <= start_save;
        pending_r <= 1'b1;
        end_seen_r <= 1'b0;
      end else if (push) begin
        nv_idx_r <= nv_idx_r + 1'b1;
      end
      if (state_r == ST_CMD && is_end) end_seen_r <= 1'b1;
      if (start_save) save_trig_r <= 1'b1;
      else if (state_r == ST_FINISH) save_trig_r <= 1'b0;
      if (state_r == ST_FINISH) pending_r <= 1'b0;
      commit_r <= wr_commit | (drained & ~end_seen_r);
      if (host_rd) host_rdata_r <= rd_mux;
    end
  end

  // Small buffer between range reads and the destination; a stalled sink halts the walk
  seg_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data({nv_idx_r, cur_addr_r, src_data}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_data_entry;
    (state_r == ST_CMD) && !is_op;
  endsequence

  sequence s_addr_fetch;
    (state_r == ST_HI) ##1 (state_r == ST_LO) ##1 (state_r == ST_MOVE);
  endsequence

  property p_data_walk;
    s_data_entry |=> s_addr_fetch;
  endproperty
  a_data_walk: assert property (p_data_walk) else $error("data entry not followed by address fetch");

  property p_len;
    s_data_entry |=> (count_r == $past(len_count)) && (count_r == {1'b0, $past(cmd_byte[6:0])} + 8'h01);
  endproperty
  a_len: assert property (p_len) else $error("byte count is not field plus one");

  property p_addr_order;
    (state_r == ST_LO) |=> (cur_addr_r == {$past(list_mem[ptr_r - 8'h01]), $past(cmd_byte)});
  endproperty
  a_addr_order: assert property (p_addr_order) else $error("start address not high byte first");

  property p_op_step;
    (state_r == ST_CMD) && is_op && !is_end && !is_commit |=> (ptr_r == $past(ptr_r) + 8'h01) && (state_r == ST_CMD);
  endproperty
  a_op_step: assert property (p_op_step) else $error("opcode step wrong");

  property p_entry_step;
    s_data_entry ##1 s_addr_fetch |-> (ptr_r == $past(ptr_r, 3) + 8'h03);
  endproperty
  a_entry_step: assert property (p_entry_step) else $error("transfer entry not three bytes");

  property p_commit_host;
    wr_commit |=> commit_pulse ##1 !commit_pulse || $past(wr_commit);
  endproperty
  a_commit_host: assert property (p_commit_host) else $error("commit write gave no one-cycle pulse");

  property p_commit_op;
    (state_r == ST_DRAIN) && !f_out_valid && !end_seen_r |=> commit_pulse && (state_r == ST_CMD);
  endproperty
  a_commit_op: assert property (p_commit_op) else $error("commit code gave no pulse");

  property p_end_stop;
    (state_r == ST_CMD) && is_end |=> (state_r == ST_DRAIN) && end_seen_r;
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("end code did not stop the walk");

  property p_pending;
    start |=> pending ##0 (pending throughout (state_r != ST_IDLE)[*1]);
  endproperty
  a_pending: assert property (p_pending) else $error("pending not raised at start");

  property p_save_clear;
    (state_r == ST_FINISH) |=> !pending && !save_trig_r && (state_r == ST_IDLE);
  endproperty
  a_save_clear: assert property (p_save_clear) else $error("save trigger or pending not cleared");

  property p_range_only;
    push |-> (count_r != 8'h00) && (state_r == ST_MOVE);
  endproperty
  a_range_only: assert property (p_range_only) else $error("byte moved outside a named range");

endmodule // eeprom_segment_interpreter

`default_nettype wire

// *** nv_partner.sv ***
// Partner model: buffer register space and nonvolatile array facing the interpreter
`timescale 1ns/10ps
`default_nettype none

module nv_partner #(
  parameter int AW = 10
) (
  input wire logic mclk,
  input wire logic slow,
  input wire logic [15:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  input wire logic [AW-1:0] nv_rd_addr,
  output logic [7:0] nv_rd_data,
  input wire logic nv_wr_valid,
  output logic nv_wr_ready,
  input wire logic [AW-1:0] nv_wr_addr,
  input wire logic [7:0] nv_wr_data,
  input wire logic reg_wr_valid,
  output logic reg_wr_ready,
  input wire logic [15:0] reg_wr_addr,
  input wire logic [7:0] reg_wr_data
);
  logic [7:0] nv_mem [0:(1<<AW)-1];
  logic [7:0] reg_mem [0:65535];
  int nv_cnt = 0;
  int reg_cnt = 0;
  logic tog = 1'b0;

  // Untouched cells keep a marker so stray writes show up
  initial begin
    foreach (nv_mem[i]) nv_mem[i] = 8'hee;
    foreach (reg_mem[i]) reg_mem[i] = 8'hee;
  end

  // Read data follows the address, so a wrong address gives wrong data
  assign reg_rd_data = reg_rd_addr[7:0] ^ reg_rd_addr[15:8] ^ 8'h5a;
  assign nv_rd_data = nv_mem[nv_rd_addr];
  // Slow mode refuses every other cycle to back up the FIFO
  assign nv_wr_ready = !slow || tog;
  assign reg_wr_ready = !slow || tog;

  // Accept bytes only on valid and ready
  always @(posedge mclk) begin
    tog <= !tog;
    if (nv_wr_valid && nv_wr_ready) begin
      nv_mem[nv_wr_addr] <= nv_wr_data;
      nv_cnt <= nv_cnt + 1;
    end
    if (reg_wr_valid && reg_wr_ready) begin
      reg_mem[reg_wr_addr] <= reg_wr_data;
      reg_cnt <= reg_cnt + 1;
    end
  end
endmodule // nv_partner

`default_nettype wire

// *** tb.sv ***
// Testbench: host access sequences for the command-list interpreter
`timescale 1ns/10ps
`default_nettype none

module tb;
  import eeprom_seg_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] host_addr = 12'h000;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] host_rdata;
  logic load_req = 1'b0;
  logic slow = 1'b0;
  logic commit_pulse, pending;
  logic nv_wr_valid, nv_wr_ready, reg_wr_valid, reg_wr_ready;
  logic [15:0] reg_rd_addr, reg_wr_addr;
  logic [7:0] reg_rd_data, nv_rd_data, nv_wr_data, reg_wr_data;
  logic [9:0] nv_rd_addr, nv_wr_addr;
  int bad_count = 0;
  int cmp_count = 0;
  int commits = 0;
  int c0, r0;
  // Twelve-byte second range is long enough to fill the FIFO while the sink stalls
  logic [7:0] sv_list [8] = '{8'h01, 8'h00, 8'h10, 8'h80, 8'h0b, 8'h01, 8'h20, 8'hff};
  // Unknown opcode 0x85 must be stepped over as one byte
  logic [7:0] ld_list [11] = '{8'h00, 8'h00, 8'h40, 8'h85, 8'h01, 8'h00, 8'h50, 8'hff, 8'h00, 8'h00, 8'h60};
  logic [7:0] exp_nv;

  eeprom_segment_interpreter #(.NV_AW(10)) u_dut (.mclk(mclk), .rst(rst), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .load_req(load_req), .commit_pulse(commit_pulse), .pending(pending), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data), .nv_wr_valid(nv_wr_valid),
    .nv_wr_ready(nv_wr_ready), .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data), .reg_wr_valid(reg_wr_valid),
    .reg_wr_ready(reg_wr_ready), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));

  nv_partner #(.AW(10)) u_nv (.mclk(mclk), .slow(slow), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
    .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data), .nv_wr_valid(nv_wr_valid), .nv_wr_ready(nv_wr_ready),
    .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data), .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));

  // 200 MHz clock
  initial begin
    forever #2.5 mclk = !mclk;
  end

  // Commit pulses seen over the run; sampled mid-cycle, where the pulse is settled
  always @(negedge mclk) begin
    if (commit_pulse === 1'b1) commits++;
  end

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge mclk);
    host_wr = 1'b0;
  endtask

  // Read data is registered and holds until the next read
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
    @(negedge mclk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge mclk);
    host_rd = 1'b0;
    chk(nm, exp, host_rdata);
  endtask

  // Bounded wait for the transfer engine to go idle
  task automatic wait_idle();
    for (int n = 0; n < 3000 && pending !== 1'b0; n++) @(negedge mclk);
    chk("idle", 8'h00, {7'b0, pending});
  endtask

  task automatic close_out();
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Whole run is a few thousand cycles; this is far beyond it
  initial begin
    #100000;
    bad_count++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    rd(LIST_BASE, 8'h7f, "list_00");
    rd(LIST_BASE + 12'h005, 8'h80, "list_05");
    rd(LIST_BASE + 12'h00a, 8'h01, "list_0a");
    rd(LIST_BASE + 12'h00c, 8'h33, "list_0c");
    rd(LIST_BASE + 12'h00f, {1'b1, OP_COMMIT_CODE}, "list_0f");
    rd(LIST_BASE + 12'h010, {1'b1, OP_END_CODE}, "list_10");
    rd(12'h100, 8'h00, "unmapped");
    rd(PENDING_OFS, 8'h00, "pend_rst");
    wr(COMMIT_OFS, 8'h01);
    chk("commit_wr", 8'h01, {7'b0, commit_pulse});
    // Save: two ranges with a commit between, far side stalling
    foreach (sv_list[i]) wr(LIST_BASE + 12'(i), sv_list[i]);
    wr(LIST_LAST, 8'hff);
    rd(LIST_BASE + 12'h005, 8'h01, "list_rw");
    slow = 1'b1;
    c0 = commits;
    wr(SAVE_OFS, 8'h01);
    chk("pend_save", 8'h01, {7'b0, pending});
    rd(SAVE_OFS, 8'h01, "trig_busy");
    wr(SAVE_OFS, 8'h01);
    wait_idle();
    rd(SAVE_OFS, 8'h00, "trig_done");
    rd(PENDING_OFS, 8'h00, "pend_done");
    // Two bytes from 0x0010, twelve from 0x0120, then an untouched cell
    for (int i = 0; i < 15; i++) begin
      exp_nv = (i < 2) ? pat(16'h0010 + 16'(i)) : (i < 14) ? pat(16'h011e + 16'(i)) : 8'hee;
      chk("nv_mem", exp_nv, u_nv.nv_mem[i]);
    end
    chk("nv_cnt", 8'd14, 8'(u_nv.nv_cnt));
    chk("save_commit", 8'(c0 + 1), 8'(commits));
    repeat (2000) @(negedge mclk);
    // Load: one-byte and two-byte entries, end code, then an entry that must not run
    foreach (ld_list[i]) wr(LIST_BASE + 12'(i), ld_list[i]);
    slow = 1'b0;
    c0 = commits;
    r0 = u_nv.reg_cnt;
    @(negedge mclk);
    load_req = 1'b1;
    repeat (6) @(negedge mclk);
    chk("pend_load", 8'h01, {7'b0, pending});
    load_req = 1'b0;
    wait_idle();
    chk("reg_40", pat(16'h0010), u_nv.reg_mem[16'h0040]);
    chk("reg_41", 8'hee, u_nv.reg_mem[16'h0041]);
    chk("reg_50", pat(16'h0011), u_nv.reg_mem[16'h0050]);
    chk("reg_51", pat(16'h0120), u_nv.reg_mem[16'h0051]);
    chk("reg_60", 8'hee, u_nv.reg_mem[16'h0060]);
    chk("reg_cnt", 8'd3, 8'(u_nv.reg_cnt - r0));
    chk("load_commit", 8'(c0), 8'(commits));
    // Mid-run reset must bring back the power-up list
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk("pend_rst2", 8'h00, {7'b0, pending});
    rd(LIST_BASE, 8'h7f, "list_rst2");
    rd(LIST_BASE + 12'h005, 8'h80, "list_rst2_05");
    close_out();
  end
endmodule // tb

`default_nettype wire
